// >>> verilog/sram_tap_defines.svh
/*
 * Constants of the memory boundary-scan test port: widths, instruction
 * codes, capture patterns and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SRAM_TAP_DEFINES_SVH
`define SRAM_TAP_DEFINES_SVH

// Instruction register
`define TAP_IR_W          3
`define TAP_IR_CAPTURE    2'h1
`define TAP_IR_CAPTURE_MSB 1'h0

// Instruction codes
`define TAP_OP_EXTEST     3'h0
`define TAP_OP_IDCODE     3'h1
`define TAP_OP_SAMPLE_Z   3'h2
`define TAP_OP_PRELOAD    3'h4
`define TAP_OP_BYPASS     3'h7

// Data registers
`define TAP_ID_W          32
`define TAP_BSR_W         110
`define TAP_BSR_OUTEN_BIT 109
`define TAP_BYPASS_CAPTURE 1'h0
`define TAP_BSR_RESET     110'h0

// Identification code, value arbitrary, bit 0 set as the standard asks
`define TAP_IDCODE_VALUE  32'h0A5C_3001

// Consecutive high mode-select edges that force test-logic-reset
`define TAP_TMS_RESET_EDGES 3'h5

`endif

// >>> verilog/sram_tap_pkg.sv
/*
 * Types of the memory boundary-scan test port.
 * Assumes nothing beyond the defines header.
 */
`include "sram_tap_defines.svh"

package sram_tap_pkg;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
    UPDATE_IR
  } tap_state_t;

  typedef logic [`TAP_IR_W-1:0] tap_instr_t;

endpackage

// >>> verilog/tap_fsm.sv
/*
 * Sixteen-state test port controller, stepped by a rising test clock
 * strobe from the parent.
 * Assumes tck_rise_in is a one-cycle strobe and tms_in is already
 * synchronised to core_clk_in.
 */
`timescale 1ns/1ps
`include "sram_tap_defines.svh"

module tap_fsm
  import sram_tap_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  // Test clock strobe and mode select
  input  wire logic       tck_rise_in,
  input  wire logic       tms_in,
  // Controller state
  output tap_state_t      state_out
);

  tap_state_t state_reg;
  tap_state_t state_next;
  logic [2:0] ones_reg;

  function automatic tap_state_t step(input tap_state_t s, input logic m);
    tap_state_t n;
    n = s;
    unique case (s)
      TEST_LOGIC_RESET: n = m ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE:    n = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR:        n = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR:       n = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:         n = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:         n = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:         n = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:         n = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:        n = m ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR:        n = m ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR:       n = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:         n = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:         n = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:         n = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:         n = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:        n = m ? SELECT_DR : RUN_TEST_IDLE;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State register

  assign state_next = tck_rise_in ? step(state_reg, tms_in) : state_reg;
  assign state_out  = state_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= TEST_LOGIC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ones_reg <= 3'h0;
    end else if (tck_rise_in) begin
      ones_reg <= !tms_in ? 3'h0 :
                  (ones_reg == `TAP_TMS_RESET_EDGES) ? ones_reg :
                  3'(ones_reg + 3'h1);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  state_on_tck_a: assert property (
    (state_reg != $past(state_reg)) |-> $past(tck_rise_in))
    else $error("State moved without a test clock edge");

  tms_reset_a: assert property (
    (ones_reg == `TAP_TMS_RESET_EDGES) |-> (state_reg == TEST_LOGIC_RESET))
    else $error("Five high mode-select edges did not reset");

  capture_ir_a: assert property (
    (tck_rise_in && state_reg == SELECT_IR && !tms_in)
      |=> (state_reg == CAPTURE_IR))
    else $error("Select-IR did not lead to Capture-IR");

endmodule

// >>> verilog/sram_tap.sv
/*
 * Boundary-scan test access port of the memory: input synchronisers,
 * instruction register, bypass, identification and boundary registers,
 * and the serial output stage.
 * Assumes the test pins arrive asynchronously to core_clk_in, a test
 * clock at most a quarter of core_clk_in, and a boundary ring that is
 * synchronous to core_clk_in.
 */
`timescale 1ns/1ps
`include "sram_tap_defines.svh"

module sram_tap
  import sram_tap_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_b_in,
  // Test pins
  input  wire logic                  tck_in,
  input  wire logic                  tms_in,
  input  wire logic                  tdi_in,
  output logic                       tdo_out,
  output logic                       tdo_oe_out,
  // Boundary ring
  input  wire logic [`TAP_BSR_W-1:0] bsr_capture_in,
  output logic      [`TAP_BSR_W-1:0] bsr_update_out,
  output logic                       extest_out,
  output logic                       sample_z_out
);

  logic                  tck_s1_reg, tck_s2_reg, tck_s3_reg;
  logic                  tms_s1_reg, tms_s2_reg;
  logic                  tdi_s1_reg, tdi_s2_reg;
  logic                  tck_rise, tck_fall;
  tap_state_t            state;
  tap_instr_t            ir_reg, ir_next;
  tap_instr_t            ir_shift_reg, ir_shift_next;
  logic                  byp_reg, byp_next;
  logic [`TAP_ID_W-1:0]  id_shift_reg, id_shift_next;
  logic [`TAP_BSR_W-1:0] bsr_shift_reg, bsr_shift_next;
  logic [`TAP_BSR_W-1:0] bsr_update_reg, bsr_update_next;
  logic                  tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
  logic                  extest_reg, sample_z_reg;
  logic                  sel_id, sel_bsr, sel_byp, dr_lsb;
  logic                  cap_ir, sh_ir, cap_dr, sh_dr, upd_dr, in_shift;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, open mode-select and data inputs idle high, test clock low

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tck_s1_reg <= 1'h0;
      tck_s2_reg <= 1'h0;
      tck_s3_reg <= 1'h0;
      tms_s1_reg <= 1'h1;
      tms_s2_reg <= 1'h1;
      tdi_s1_reg <= 1'h1;
      tdi_s2_reg <= 1'h1;
    end else begin
      tck_s1_reg <= tck_in;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
      tms_s1_reg <= tms_in;
      tms_s2_reg <= tms_s1_reg;
      tdi_s1_reg <= tdi_in;
      tdi_s2_reg <= tdi_s1_reg;
    end
  end

  assign tck_rise = tck_s2_reg && !tck_s3_reg;
  assign tck_fall = !tck_s2_reg && tck_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  // Controller

  tap_fsm tap_fsm_inst (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .tck_rise_in (tck_rise),
    .tms_in      (tms_s2_reg),
    .state_out   (state)
  );

  assign cap_ir   = tck_rise && (state == CAPTURE_IR);
  assign sh_ir    = tck_rise && (state == SHIFT_IR);
  assign cap_dr   = tck_rise && (state == CAPTURE_DR);
  assign sh_dr    = tck_rise && (state == SHIFT_DR);
  assign upd_dr   = tck_rise && (state == UPDATE_DR);
  assign in_shift = (state == SHIFT_IR) || (state == SHIFT_DR);

  ////////////////////////////////////////////////////////////////////////
  // Instruction register

  assign ir_shift_next =
    cap_ir ? {`TAP_IR_CAPTURE_MSB, `TAP_IR_CAPTURE} :
    sh_ir  ? {tdi_s2_reg, ir_shift_reg[`TAP_IR_W-1:1]} :
    ir_shift_reg;

  assign ir_next =
    (state == TEST_LOGIC_RESET) ? `TAP_OP_IDCODE :
    (tck_rise && state == UPDATE_IR) ? ir_shift_reg :
    ir_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ir_shift_reg <= `TAP_OP_IDCODE;
      ir_reg       <= `TAP_OP_IDCODE;
    end else begin
      ir_shift_reg <= ir_shift_next;
      ir_reg       <= ir_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data registers

  assign sel_id  = (ir_reg == `TAP_OP_IDCODE);
  assign sel_bsr = (ir_reg == `TAP_OP_EXTEST) ||
                   (ir_reg == `TAP_OP_SAMPLE_Z) ||
                   (ir_reg == `TAP_OP_PRELOAD);
  assign sel_byp = !sel_id && !sel_bsr;

  assign byp_next =
    (cap_dr && sel_byp) ? `TAP_BYPASS_CAPTURE :
    (sh_dr && sel_byp)  ? tdi_s2_reg : byp_reg;

  assign id_shift_next =
    (cap_dr && sel_id) ? `TAP_IDCODE_VALUE :
    (sh_dr && sel_id)  ? {tdi_s2_reg, id_shift_reg[`TAP_ID_W-1:1]} :
    id_shift_reg;

  assign bsr_shift_next =
    (cap_dr && sel_bsr) ? bsr_capture_in :
    (sh_dr && sel_bsr)  ? {tdi_s2_reg, bsr_shift_reg[`TAP_BSR_W-1:1]} :
    bsr_shift_reg;

  assign bsr_update_next =
    (state == TEST_LOGIC_RESET) ? `TAP_BSR_RESET :
    (upd_dr && sel_bsr) ? bsr_shift_reg : bsr_update_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byp_reg        <= 1'h0;
      id_shift_reg   <= `TAP_ID_W'(0);
      bsr_shift_reg  <= `TAP_BSR_RESET;
      bsr_update_reg <= `TAP_BSR_RESET;
      extest_reg     <= 1'h0;
      sample_z_reg   <= 1'h0;
    end else begin
      byp_reg        <= byp_next;
      id_shift_reg   <= id_shift_next;
      bsr_shift_reg  <= bsr_shift_next;
      bsr_update_reg <= bsr_update_next;
      extest_reg     <= (ir_reg == `TAP_OP_EXTEST);
      sample_z_reg   <= (ir_reg == `TAP_OP_SAMPLE_Z);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output, launched on falling test clock

  assign dr_lsb   = sel_id ? id_shift_reg[0] :
                    sel_bsr ? bsr_shift_reg[0] : byp_reg;
  assign tdo_next = tck_fall ?
    ((state == SHIFT_IR) ? ir_shift_reg[0] : dr_lsb) : tdo_reg;
  assign tdo_oe_next = tck_fall ? in_shift : tdo_oe_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tdo_reg    <= 1'h0;
      tdo_oe_reg <= 1'h0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  assign tdo_out        = tdo_reg;
  assign tdo_oe_out     = tdo_oe_reg;
  assign bsr_update_out = bsr_update_reg;
  assign extest_out     = extest_reg;
  assign sample_z_out   = sample_z_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  tdo_on_fall_a: assert property (
    (tdo_out != $past(tdo_out)) |-> $past(tck_fall))
    else $error("Serial output moved off a falling edge");

  tdo_enable_a: assert property (
    (tck_fall && !in_shift) |=> !tdo_oe_out)
    else $error("Serial output driven outside shift states");

  tdo_lsb_a: assert property (
    (tck_fall && state == SHIFT_IR) |=> (tdo_out == $past(ir_shift_reg[0])))
    else $error("Serial output is not the low bit");

  ir_capture_a: assert property (
    cap_ir |=> (ir_shift_reg[1:0] == `TAP_IR_CAPTURE))
    else $error("Capture-IR did not load 01");

  ir_shift_in_a: assert property (
    sh_ir |=> (ir_shift_reg[2] == $past(tdi_s2_reg)) &&
              (ir_shift_reg[1:0] == $past(ir_shift_reg[2:1])))
    else $error("Instruction shift not toward low end");

  ir_hold_a: assert property (
    (!cap_ir && !sh_ir) |=> (ir_shift_reg == $past(ir_shift_reg)))
    else $error("Instruction shifter moved outside shift");

  ir_reset_a: assert property (
    (state == TEST_LOGIC_RESET) |=> (ir_reg == `TAP_OP_IDCODE))
    else $error("Reset did not load identification instruction");

  bypass_zero_a: assert property (
    (cap_dr && sel_byp) |=> (byp_reg == 1'h0))
    else $error("Bypass did not capture zero");

  id_capture_a: assert property (
    (cap_dr && sel_id) |=> (id_shift_reg == `TAP_IDCODE_VALUE) &&
                           (bsr_shift_reg == $past(bsr_shift_reg)))
    else $error("Wrong register captured for identification");

endmodule

// >>> dv/jtag_ctrl_model.sv
/*
 * Board-side boundary-scan controller model: drives test clock, mode
 * select and serial data, and samples the serial output wire.
 * Assumes a 50 MHz core_clk_in; one test clock period is 8 of its cycles.
 */
`timescale 1ns/1ps

module jtag_ctrl_model (
  // Bench clock
  input  wire logic core_clk_in,
  // Test pins
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in
);

  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // One test clock period: inputs change at the fall, output read after rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge core_clk_in);
    tck_out <= 1'b0;
    tms_out <= tms;
    tdi_out <= tdi;
    repeat (4) @(posedge core_clk_in);
    tck_out <= 1'b1;
    @(posedge core_clk_in);
    tdo = tdo_in;
    repeat (2) @(posedge core_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Full scan from idle back to idle, clock left standing low
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir)
      step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    @(posedge core_clk_in);
    tck_out <= 1'b0;
    tdi_out <= 1'b1;
    repeat (4) @(posedge core_clk_in);
  endtask

endmodule

// >>> dv/sram_tap_tb_top.sv
/*
 * Self-checking bench of the memory boundary-scan test port.
 * Assumes the defines header and package are compiled first and the
 * controller model drives the test pins.
 */
`timescale 1ns/1ps
`include "sram_tap_defines.svh"

`define CHECK_EQ(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
  end \
end

module sram_tap_tb_top;

  logic                  core_clk_in;
  logic                  rst_b_in;
  logic                  tck_in;
  logic                  tms_in;
  logic                  tdi_in;
  logic                  tdo_out;
  logic                  tdo_oe_out;
  wire                   tdo_wire;
  logic [`TAP_BSR_W-1:0] bsr_capture_in;
  logic [`TAP_BSR_W-1:0] bsr_update_out;
  logic                  extest_out;
  logic                  sample_z_out;
  logic                  tck_neg_q;
  logic [1:0]            tdo_neg_q;
  logic [127:0]          dout;
  int                    n_fail;
  int                    n_tests;

  assign tdo_wire = tdo_oe_out ? tdo_out : 1'bz;

  sram_tap sram_tap_inst (
    .core_clk_in    (core_clk_in),
    .rst_b_in       (rst_b_in),
    .tck_in         (tck_in),
    .tms_in         (tms_in),
    .tdi_in         (tdi_in),
    .tdo_out        (tdo_out),
    .tdo_oe_out     (tdo_oe_out),
    .bsr_capture_in (bsr_capture_in),
    .bsr_update_out (bsr_update_out),
    .extest_out     (extest_out),
    .sample_z_out   (sample_z_out)
  );

  jtag_ctrl_model jtag_ctrl_model_inst (
    .core_clk_in (core_clk_in),
    .tck_out     (tck_in),
    .tms_out     (tms_in),
    .tdi_out     (tdi_in),
    .tdo_in      (tdo_wire)
  );

  always #10 core_clk_in = ~core_clk_in;

  ////////////////////////////////////////////////////////////////////////
  // Output must not move while the test clock stays high
  always @(negedge core_clk_in) begin
    if (rst_b_in && tck_in && tck_neg_q)
      `CHECK_EQ({tdo_oe_out, tdo_out}, tdo_neg_q)
    tck_neg_q <= tck_in;
    tdo_neg_q <= {tdo_oe_out, tdo_out};
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic load_ir(input logic [2:0] code);
    jtag_ctrl_model_inst.scan(1'b1, 3, {125'h0, code}, dout);
    `CHECK_EQ(dout[2:0], {`TAP_IR_CAPTURE_MSB, `TAP_IR_CAPTURE})
    `CHECK_EQ(tdo_oe_out, 1'b0)
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic power_up_idcode();
    logic t;
    jtag_ctrl_model_inst.step(1'b0, 1'b1, t);
    `CHECK_EQ(tdo_oe_out, 1'b0)
    jtag_ctrl_model_inst.scan(1'b0, 64, {128{1'b1}}, dout);
    `CHECK_EQ(dout[31:0], `TAP_IDCODE_VALUE)
    `CHECK_EQ(dout[63:32], 32'hFFFF_FFFF)
  endtask

  task automatic bypass_codes();
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      jtag_ctrl_model_inst.scan(1'b0, 8, 128'hB4, dout);
      `CHECK_EQ(dout[7:0], 8'h68)
    end
  endtask

  task automatic boundary_modes();
    logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
    bsr_capture_in <= {10{11'h5A3}};
    load_ir(`TAP_OP_PRELOAD);
    jtag_ctrl_model_inst.scan(1'b0, 110, {18'h0, {10{11'h1C6}}}, dout);
    `CHECK_EQ(dout[109:0], {10{11'h5A3}})
    `CHECK_EQ(bsr_update_out, {10{11'h1C6}})
    foreach (codes[i]) begin
      load_ir(codes[i]);
      `CHECK_EQ(extest_out, codes[i] == `TAP_OP_EXTEST)
      `CHECK_EQ(sample_z_out, codes[i] == `TAP_OP_SAMPLE_Z)
    end
    load_ir(`TAP_OP_EXTEST);
    jtag_ctrl_model_inst.scan(1'b0, 110, 128'h0, dout);
    `CHECK_EQ(dout[109:0], {10{11'h5A3}})
  endtask

  task automatic tms_reset();
    logic t;
    jtag_ctrl_model_inst.step(1'b1, 1'b1, t);
    jtag_ctrl_model_inst.step(1'b0, 1'b1, t);
    jtag_ctrl_model_inst.step(1'b0, 1'b1, t);
    repeat (5) jtag_ctrl_model_inst.step(1'b1, 1'b1, t);
    jtag_ctrl_model_inst.step(1'b0, 1'b1, t);
    repeat (4) @(posedge core_clk_in);
    `CHECK_EQ(extest_out, 1'b0)
    `CHECK_EQ(bsr_update_out, {`TAP_BSR_W{1'b0}})
    jtag_ctrl_model_inst.scan(1'b0, 32, 128'h0, dout);
    `CHECK_EQ(dout[31:0], `TAP_IDCODE_VALUE)
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial begin
    core_clk_in = 1'b0;
    rst_b_in = 1'b0;
    bsr_capture_in = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    power_up_idcode();
    bypass_codes();
    boundary_modes();
    tms_reset();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge core_clk_in);
    n_fail++;
    tally_and_finish();
  end

endmodule
